//--- common/usb_ep_pkg.sv
// Shared constants for the endpoint data handshake logic and its driver.
package usb_ep_pkg;
	localparam int NUM_EP = 2;
	localparam int EP_W = 1;
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam int ST_W = 12;
	localparam logic [1:0] DUAL_MASK = 2'h2;
	// Software commands carried over the interface.
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_FIFO_WR = 4'h1;
	localparam logic [3:0] OP_FIFO_RD = 4'h2;
	localparam logic [3:0] OP_SET_TXRDY = 4'h3;
	localparam logic [3:0] OP_CLR_TX_COMPLETE = 4'h4;
	localparam logic [3:0] OP_CLR_RXB0 = 4'h5;
	localparam logic [3:0] OP_CLR_RXB1 = 4'h6;
	localparam logic [3:0] OP_SET_STALL = 4'h7;
	localparam logic [3:0] OP_CLR_STALL = 4'h8;
	localparam logic [3:0] OP_CLR_STALL_HANDSHAKE_SENT = 4'h9;
	// Bit positions of the endpoint control and status word.
	localparam int ST_TXRDY = 0;
	localparam int ST_TX_COMPLETE = 1;
	localparam int ST_RXB0 = 2;
	localparam int ST_RXB1 = 3;
	localparam int ST_STALLREQ = 4;
	localparam int ST_STALL_HANDSHAKE_SENT = 5;
	localparam int ST_DUAL = 6;
	localparam int ST_CNT_LSB = 8;
	// Handshake codes on the link.
	localparam logic [1:0] HS_ACK = 2'h1;
	localparam logic [1:0] HS_NAK = 2'h2;
	localparam logic [1:0] HS_STALL = 2'h3;
	// Driver register offsets and command, read data and status word fields.
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_RDATA = 8'h04;
	localparam logic [7:0] REG_STATUS0 = 8'h08;
	localparam int CMD_EP_LSB = 4;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_FINAL = 16;
	localparam int RD_REFUSED = 8;
	localparam int STAT_IRQ = 16;
endpackage : usb_ep_pkg

//--- common/usb_ep_if.sv
// Interface between the endpoint logic and its software-side driver.
`timescale 1ns/1ps
interface usb_ep_if;
	logic cmd_valid;
	logic [3:0] cmd_op;
	logic [usb_ep_pkg::EP_W-1:0] cmd_ep;
	logic [7:0] cmd_data;
	logic rd_valid;
	logic [7:0] rd_data;
	logic [usb_ep_pkg::NUM_EP-1:0][usb_ep_pkg::ST_W-1:0] ep_status;
	logic [usb_ep_pkg::NUM_EP-1:0] ep_irq;
	modport dev (
		input cmd_valid, cmd_op, cmd_ep, cmd_data,
		output rd_valid, rd_data, ep_status, ep_irq
	);
	modport drv (
		output cmd_valid, cmd_op, cmd_ep, cmd_data,
		input rd_valid, rd_data, ep_status, ep_irq
	);
endinterface : usb_ep_if

//--- core/usb_ep_device.sv
// Endpoint data handshake logic facing the USB host link.
//
// Summary of operation
// R1 - Software checks ready flag clear before loading
// R2 - Software writes bytes then sets ready flag
// R3 - Transmit complete set only on host ACK
// R4 - Hardware clears ready flag after sending
// R5 - Interrupt held while transmit complete set
// R6 - Software clears complete after next ready
// R7 - Isochronous IN uses two alternating banks
// R8 - Banks alternate, each released after sending
// R9 - Second bank readied only after completion
// R10 - IN token without ready packet gets NAK
// R11 - OUT NAKed while busy, else stored, ACKed
// R12 - Bank zero flag set, interrupt held
// R13 - Received byte count readable in status
// R14 - Read whole packet before clearing flag
// R15 - Two-bank OUT accepts back to back
// R16 - Bank one flag set, interrupt held
// R17 - Software clears bank flags strictly alternately
// R18 - Forced stall answered, stall sent flagged
// R19 - Software clears stall sent flag
// R20 - Protocol stall only on control transfers
// R21 - Each endpoint keeps independent state
// R22 - Out of turn flag writes rejected
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module usb_ep_device #(
	parameter int NUM_EP = usb_ep_pkg::NUM_EP,
	parameter int DEPTH = usb_ep_pkg::FIFO_DEPTH,
	parameter logic [usb_ep_pkg::NUM_EP-1:0] DUAL = usb_ep_pkg::DUAL_MASK
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Software side.
	usb_ep_if.dev sw,
	// Host tokens and OUT data.
	input wire logic tok_valid_i,
	input wire logic tok_out_i,
	input wire logic [usb_ep_pkg::EP_W-1:0] tok_ep_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_end_i,
	// Host answer to IN data.
	input wire logic hs_valid_i,
	input wire logic hs_ack_i,
	// IN data and device handshakes.
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	output logic tx_done_o,
	output logic hs_valid_o,
	output logic [1:0] hs_code_o
);
	localparam int CW = usb_ep_pkg::CNT_W;
	localparam int PW = usb_ep_pkg::PTR_W;

	typedef enum logic [3:0] {
		L_IDLE = 4'h1,
		L_TX = 4'h2,
		L_WAIT = 4'h4,
		L_RX = 4'h8
	} link_type;

	typedef struct packed {
		logic [1:0] tx_full;
		logic [1:0] rx_full;
		logic tx_complete;
		logic stall_req;
		logic stall_sent;
		logic sw_bank;
		logic hw_bank;
		logic [CW-1:0] ptr;
		logic [1:0][CW-1:0] cnt;
		logic [1:0][DEPTH-1:0][7:0] mem;
	} ep_type;

	typedef struct packed {
		link_type link;
		logic [usb_ep_pkg::EP_W-1:0] ep;
		logic [CW-1:0] pos;
		logic rx_ok;
		logic rx_stall;
		ep_type [NUM_EP-1:0] eps;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic tx_done;
		logic hs_valid;
		logic [1:0] hs_code;
		logic rd_valid;
		logic [7:0] rd_data;
		logic [NUM_EP-1:0][usb_ep_pkg::ST_W-1:0] status;
		logic [NUM_EP-1:0] irq;
	} state_type;

	state_type r;
	state_type n;

	// ------------------------------------------------------------
	// Status word packing
	// ------------------------------------------------------------
	function automatic logic [usb_ep_pkg::ST_W-1:0] st_pack(input ep_type e, input logic dual);
		logic [usb_ep_pkg::ST_W-1:0] s;
		s = '0;
		s[usb_ep_pkg::ST_TXRDY] = |e.tx_full;
		s[usb_ep_pkg::ST_TX_COMPLETE] = e.tx_complete;
		s[usb_ep_pkg::ST_RXB0] = e.rx_full[0];
		s[usb_ep_pkg::ST_RXB1] = e.rx_full[1];
		s[usb_ep_pkg::ST_STALLREQ] = e.stall_req;
		s[usb_ep_pkg::ST_STALL_HANDSHAKE_SENT] = e.stall_sent;
		s[usb_ep_pkg::ST_DUAL] = dual;
		s[usb_ep_pkg::ST_CNT_LSB +: CW] = e.cnt[e.sw_bank]; // see R13
		return s;
	endfunction : st_pack

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic b;
		logic [CW-1:0] p;
		b = 1'b0;
		p = '0;
		n = r;
		n.tx_valid = 1'b0;
		n.tx_done = 1'b0;
		n.hs_valid = 1'b0;
		n.rd_valid = 1'b0;
		// Software commands are applied first so that a hardware set in the same
		// cycle overrides a software clear of the same flag.
		if (sw.cmd_valid) begin
			b = n.eps[sw.cmd_ep].sw_bank;
			p = n.eps[sw.cmd_ep].ptr;
			unique case (sw.cmd_op)
				usb_ep_pkg::OP_FIFO_WR: begin
					// Writes into a bank that is handed to hardware are dropped.
					if (!n.eps[sw.cmd_ep].tx_full[b] && !n.eps[sw.cmd_ep].rx_full[b]
							&& p < CW'(DEPTH)) begin // see R22
						n.eps[sw.cmd_ep].mem[b][p[PW-1:0]] = sw.cmd_data;
						n.eps[sw.cmd_ep].ptr = p + 1'b1;
					end
				end
				usb_ep_pkg::OP_FIFO_RD: begin
					n.rd_valid = 1'b1;
					n.rd_data = 8'h00;
					if (n.eps[sw.cmd_ep].rx_full[b] && p < n.eps[sw.cmd_ep].cnt[b]) begin
						n.rd_data = n.eps[sw.cmd_ep].mem[b][p[PW-1:0]];
						n.eps[sw.cmd_ep].ptr = p + 1'b1;
					end
				end
				usb_ep_pkg::OP_SET_TXRDY: begin
					if (!n.eps[sw.cmd_ep].tx_full[b] && !n.eps[sw.cmd_ep].rx_full[b]) begin // see R22
						n.eps[sw.cmd_ep].tx_full[b] = 1'b1;
						n.eps[sw.cmd_ep].cnt[b] = p;
						n.eps[sw.cmd_ep].ptr = '0;
						n.eps[sw.cmd_ep].sw_bank = DUAL[sw.cmd_ep] ? ~b : 1'b0; // see R7, R8
					end
				end
				usb_ep_pkg::OP_CLR_TX_COMPLETE: begin
					n.eps[sw.cmd_ep].tx_complete = 1'b0;
				end
				usb_ep_pkg::OP_CLR_RXB0,
				usb_ep_pkg::OP_CLR_RXB1: begin
					b = (sw.cmd_op == usb_ep_pkg::OP_CLR_RXB1);
					if (n.eps[sw.cmd_ep].rx_full[b]) begin // see R22
						n.eps[sw.cmd_ep].rx_full[b] = 1'b0;
						n.eps[sw.cmd_ep].ptr = '0;
						n.eps[sw.cmd_ep].sw_bank = DUAL[sw.cmd_ep] ? ~b : 1'b0; // see R15
					end
				end
				usb_ep_pkg::OP_SET_STALL: begin
					n.eps[sw.cmd_ep].stall_req = 1'b1;
				end
				usb_ep_pkg::OP_CLR_STALL: begin
					n.eps[sw.cmd_ep].stall_req = 1'b0;
				end
				usb_ep_pkg::OP_CLR_STALL_HANDSHAKE_SENT: begin
					n.eps[sw.cmd_ep].stall_sent = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// Link sequencing; only the addressed endpoint is touched.
		b = n.eps[n.ep].hw_bank; // see R21
		unique case (r.link)
			L_IDLE: begin
				if (tok_valid_i) begin
					n.ep = tok_ep_i;
					n.pos = '0;
					b = n.eps[tok_ep_i].hw_bank;
					if (tok_out_i) begin
						n.link = L_RX;
						n.rx_stall = n.eps[tok_ep_i].stall_req;
						// The bank is free only when software has released it.
						n.rx_ok = !n.eps[tok_ep_i].rx_full[b] && !n.eps[tok_ep_i].tx_full[b]; // see R11
					end else if (n.eps[tok_ep_i].stall_req) begin
						n.hs_valid = 1'b1;
						n.hs_code = usb_ep_pkg::HS_STALL; // see R18
						n.eps[tok_ep_i].stall_sent = 1'b1; // see R18
					end else if (n.eps[tok_ep_i].tx_full[b]) begin
						n.link = L_TX;
					end else begin
						n.hs_valid = 1'b1;
						n.hs_code = usb_ep_pkg::HS_NAK; // see R10
					end
				end
			end
			L_TX: begin
				if (r.pos < n.eps[r.ep].cnt[b]) begin
					n.tx_valid = 1'b1;
					n.tx_byte = n.eps[r.ep].mem[b][r.pos[PW-1:0]];
					n.pos = r.pos + 1'b1;
				end else begin
					n.tx_done = 1'b1;
					n.link = L_WAIT;
				end
			end
			L_WAIT: begin
				if (hs_valid_i) begin
					n.link = L_IDLE;
					// Without an ACK the bank stays ready and is resent on the next IN.
					if (hs_ack_i) begin
						n.eps[r.ep].tx_complete = 1'b1; // see R3
						n.eps[r.ep].tx_full[b] = 1'b0; // see R4
						n.eps[r.ep].hw_bank = DUAL[r.ep] ? ~b : 1'b0; // see R8
					end
				end
			end
			L_RX: begin
				if (rx_valid_i && r.rx_ok && !r.rx_stall && r.pos < CW'(DEPTH)) begin
					n.eps[r.ep].mem[b][r.pos[PW-1:0]] = rx_byte_i;
					n.pos = r.pos + 1'b1;
				end
				if (rx_end_i) begin
					n.link = L_IDLE;
					n.hs_valid = 1'b1;
					if (r.rx_stall) begin
						n.hs_code = usb_ep_pkg::HS_STALL; // see R18
						n.eps[r.ep].stall_sent = 1'b1;
					end else if (r.rx_ok) begin
						n.hs_code = usb_ep_pkg::HS_ACK; // see R11
						n.eps[r.ep].rx_full[b] = 1'b1; // see R12, R16
						n.eps[r.ep].cnt[b] = n.pos; // see R13
						n.eps[r.ep].hw_bank = DUAL[r.ep] ? ~b : 1'b0; // see R15
					end else begin
						n.hs_code = usb_ep_pkg::HS_NAK; // see R11
					end
				end
			end
		endcase
		for (int i = 0; i < NUM_EP; i++) begin
			n.status[i] = st_pack(n.eps[i], DUAL[i]);
			n.irq[i] = n.eps[i].tx_complete | (|n.eps[i].rx_full) | n.eps[i].stall_sent; // see R5, R12, R16, R18
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '0;
			r.link <= L_IDLE;
		end else begin
			r <= n;
		end
	end

	assign sw.rd_valid = r.rd_valid;
	assign sw.rd_data = r.rd_data;
	assign sw.ep_status = r.status;
	assign sw.ep_irq = r.irq;
	assign tx_valid_o = r.tx_valid;
	assign tx_byte_o = r.tx_byte;
	assign tx_done_o = r.tx_done;
	assign hs_valid_o = r.hs_valid;
	assign hs_code_o = r.hs_code;
endmodule : usb_ep_device

//--- core/usb_ep_driver.sv
// Software-side driver that turns register writes into endpoint commands.
`timescale 1ns/1ps
module usb_ep_driver #(
	parameter int NUM_EP = usb_ep_pkg::NUM_EP
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Endpoint side.
	usb_ep_if.drv ep
);
	typedef struct packed {
		logic cmd_valid;
		logic [3:0] cmd_op;
		logic [usb_ep_pkg::EP_W-1:0] cmd_ep;
		logic [7:0] cmd_data;
		logic [7:0] last_rd;
		logic refused;
		logic [NUM_EP-1:0] rx_next;
		logic [NUM_EP-1:0] txrdy_seen;
		logic [31:0] rdata;
	} state_type;

	state_type r;
	state_type n;

	// ------------------------------------------------------------
	// Command guarding and register reads
	// ------------------------------------------------------------
	always_comb begin
		logic [3:0] op;
		logic [usb_ep_pkg::EP_W-1:0] e;
		logic [usb_ep_pkg::ST_W-1:0] s;
		logic ok;
		op = wdata_i[3:0];
		e = wdata_i[usb_ep_pkg::CMD_EP_LSB +: usb_ep_pkg::EP_W];
		s = ep.ep_status[e];
		ok = 1'b1;
		n = r;
		n.cmd_valid = 1'b0;
		n.rdata = '0;
		if (ep.rd_valid) begin
			n.last_rd = ep.rd_data;
		end
		if (wr_i && addr_i == usb_ep_pkg::REG_CMD) begin
			unique case (op)
				usb_ep_pkg::OP_FIFO_WR: begin
					ok = !s[usb_ep_pkg::ST_TXRDY] || s[usb_ep_pkg::ST_DUAL]; // see R1, R9
				end
				usb_ep_pkg::OP_SET_TXRDY: begin
					ok = !s[usb_ep_pkg::ST_TXRDY] || s[usb_ep_pkg::ST_TX_COMPLETE]; // see R9
				end
				usb_ep_pkg::OP_CLR_TX_COMPLETE: begin
					ok = r.txrdy_seen[e] || wdata_i[usb_ep_pkg::CMD_FINAL]; // see R6
				end
				usb_ep_pkg::OP_FIFO_RD: begin
					ok = s[usb_ep_pkg::ST_RXB0] || s[usb_ep_pkg::ST_RXB1]; // see R14
				end
				usb_ep_pkg::OP_CLR_RXB0: begin
					ok = !s[usb_ep_pkg::ST_DUAL] || !r.rx_next[e]; // see R17
				end
				usb_ep_pkg::OP_CLR_RXB1: begin
					ok = s[usb_ep_pkg::ST_DUAL] && r.rx_next[e]; // see R17
				end
				default: begin
					// Stall requests are passed on as written; clearing the
					// sent flag is how the endpoint interrupt goes away.
					ok = (op != usb_ep_pkg::OP_NONE) && (op <= usb_ep_pkg::OP_CLR_STALL_HANDSHAKE_SENT); // see R19, R20
				end
			endcase
			n.refused = !ok;
			if (ok) begin
				n.cmd_valid = 1'b1;
				n.cmd_op = op;
				n.cmd_ep = e;
				n.cmd_data = wdata_i[usb_ep_pkg::CMD_DATA_LSB +: 8]; // see R2
				// Only a packet readied while complete is showing counts as the next one.
				if (op == usb_ep_pkg::OP_SET_TXRDY && s[usb_ep_pkg::ST_TX_COMPLETE]) begin // see R6
					n.txrdy_seen[e] = 1'b1;
				end
				if (op == usb_ep_pkg::OP_CLR_TX_COMPLETE) begin
					n.txrdy_seen[e] = 1'b0;
				end
				if (op == usb_ep_pkg::OP_CLR_RXB0 && s[usb_ep_pkg::ST_DUAL]) begin
					n.rx_next[e] = 1'b1;
				end
				if (op == usb_ep_pkg::OP_CLR_RXB1) begin
					n.rx_next[e] = 1'b0;
				end
			end
		end
		if (rd_i) begin
			if (addr_i == usb_ep_pkg::REG_RDATA) begin
				n.rdata[7:0] = n.last_rd;
				n.rdata[usb_ep_pkg::RD_REFUSED] = r.refused;
			end
			for (int i = 0; i < NUM_EP; i++) begin
				if (addr_i == usb_ep_pkg::REG_STATUS0 + 8'(4 * i)) begin
					n.rdata[usb_ep_pkg::ST_W-1:0] = ep.ep_status[i];
					n.rdata[usb_ep_pkg::STAT_IRQ] = ep.ep_irq[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ep.cmd_valid = r.cmd_valid;
	assign ep.cmd_op = r.cmd_op;
	assign ep.cmd_ep = r.cmd_ep;
	assign ep.cmd_data = r.cmd_data;
	assign rdata_o = r.rdata;
endmodule : usb_ep_driver

//--- dv/usb_ep_assertions.sv
// Checker for the endpoint link handshakes and the command interface.
`timescale 1ns/1ps
module usb_ep_assertions (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Command interface.
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_op,
	input wire logic rd_valid,
	input wire logic [usb_ep_pkg::NUM_EP-1:0][usb_ep_pkg::ST_W-1:0] ep_status,
	input wire logic [usb_ep_pkg::NUM_EP-1:0] ep_irq,
	// Link.
	input wire logic tok_valid_i,
	input wire logic tok_out_i,
	input wire logic [usb_ep_pkg::EP_W-1:0] tok_ep_i,
	input wire logic rx_end_i,
	input wire logic hs_valid_i,
	input wire logic hs_ack_i,
	input wire logic tx_valid_o,
	input wire logic tx_done_o,
	input wire logic hs_valid_o,
	input wire logic [1:0] hs_code_o
);
	wire logic [11:0] s0 = ep_status[0];
	wire logic [11:0] s1 = ep_status[1];
	wire logic host_ack = hs_valid_i & hs_ack_i;
	wire logic rd_req = cmd_valid & (cmd_op == usb_ep_pkg::OP_FIFO_RD);
	wire logic in_tok = tok_valid_i & ~tok_out_i;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// ------------------------------
	// Assertions.
	// ------------------------------
	property p_irq0; ep_irq[0] == (s0[1] | s0[2] | s0[3] | s0[5]); endproperty
	a_irq0: assert property (p_irq0)
		else $error("endpoint 0 interrupt wrong");
	property p_irq1; ep_irq[1] == (s1[1] | s1[2] | s1[3] | s1[5]); endproperty
	a_irq1: assert property (p_irq1)
		else $error("endpoint 1 interrupt wrong");
	property p_nak;
		in_tok && !ep_status[tok_ep_i][0] && !ep_status[tok_ep_i][4] && !tx_valid_o && !tx_done_o
		|=> hs_valid_o && hs_code_o == 2'h2;
	endproperty
	a_nak: assert property (p_nak)
		else $error("empty IN not refused");
	property p_stall; in_tok && ep_status[tok_ep_i][4] |=> hs_valid_o && hs_code_o == 2'h3; endproperty
	a_stall: assert property (p_stall)
		else $error("stall not answered");
	property p_ssent; hs_valid_o && hs_code_o == 2'h3 |-> ##[0:2] (s0[5] | s1[5]); endproperty
	a_ssent: assert property (p_ssent)
		else $error("stall sent flag missing");
	property p_outack;
		rx_end_i && tok_ep_i == 1'b0 && !s0[0] && !s0[2] && !s0[4]
		|=> hs_valid_o && hs_code_o == 2'h1 ##[1:2] s0[2];
	endproperty
	a_outack: assert property (p_outack)
		else $error("free OUT not stored");
	property p_outnak; rx_end_i && tok_ep_i == 1'b0 && s0[2] && !s0[4] |=> hs_code_o == 2'h2; endproperty
	a_outnak: assert property (p_outnak)
		else $error("busy OUT not refused");
	property p_txc; $rose(s0[1]) || $rose(s1[1]) |-> $past(host_ack); endproperty
	a_txc: assert property (p_txc)
		else $error("transmit complete without ACK");
	property p_txr; $fell(s0[0]) || $fell(s1[0]) |-> $past(host_ack); endproperty
	a_txr: assert property (p_txr)
		else $error("ready cleared without ACK");
	property p_rd; 1'b1 |-> rd_valid == $past(rd_req); endproperty
	a_rd: assert property (p_rd)
		else $error("FIFO read answer misplaced");
	c_ack: cover property (hs_valid_o && hs_code_o == 2'h1);
	c_nak: cover property (hs_valid_o && hs_code_o == 2'h2);
	c_txc: cover property ($rose(s1[1]));
endmodule : usb_ep_assertions

//--- dv/tb_top.sv
// Self-checking bench for the endpoint logic and its driver.
`timescale 1ns/1ps
module tb_top;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic tok_valid_i = 1'b0;
	logic tok_out_i = 1'b0;
	logic [usb_ep_pkg::EP_W-1:0] tok_ep_i = 1'h0;
	logic rx_valid_i = 1'b0;
	logic [7:0] rx_byte_i = 8'h00;
	logic rx_end_i = 1'b0;
	logic hs_valid_i = 1'b0;
	logic hs_ack_i = 1'b0;
	logic tx_valid_o;
	logic [7:0] tx_byte_o;
	logic tx_done_o;
	logic hs_valid_o;
	logic [1:0] hs_code_o;
	int n_mismatch = 0;
	int compares = 0;
	int i;
	usb_ep_if bus();
	usb_ep_device usb_ep_device_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .sw(bus),
		.tok_valid_i(tok_valid_i), .tok_out_i(tok_out_i), .tok_ep_i(tok_ep_i),
		.rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_end_i(rx_end_i),
		.hs_valid_i(hs_valid_i), .hs_ack_i(hs_ack_i), .tx_valid_o(tx_valid_o),
		.tx_byte_o(tx_byte_o), .tx_done_o(tx_done_o), .hs_valid_o(hs_valid_o),
		.hs_code_o(hs_code_o));
	usb_ep_driver usb_ep_driver_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ep(bus));
	usb_ep_assertions usb_ep_assertions_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.cmd_valid(bus.cmd_valid), .cmd_op(bus.cmd_op), .rd_valid(bus.rd_valid),
		.ep_status(bus.ep_status), .ep_irq(bus.ep_irq), .tok_valid_i(tok_valid_i),
		.tok_out_i(tok_out_i), .tok_ep_i(tok_ep_i), .rx_end_i(rx_end_i),
		.hs_valid_i(hs_valid_i), .hs_ack_i(hs_ack_i), .tx_valid_o(tx_valid_o),
		.tx_done_o(tx_done_o), .hs_valid_o(hs_valid_o), .hs_code_o(hs_code_o));
	always #50 mclk_i = ~mclk_i;
	// ------------------------------
	// Checking and register access.
	// ------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic results;
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o & m, e);
	endtask : rd
	function automatic logic [7:0] sa(input int e);
		return usb_ep_pkg::REG_STATUS0 + 8'(4 * e);
	endfunction : sa
	task automatic cmd(input logic [3:0] op, input logic e, input logic [7:0] d, input logic f);
		wr(usb_ep_pkg::REG_CMD, {15'h0, f, d, 3'h0, e, op});
	endtask : cmd
	// ------------------------------
	// Host link.
	// ------------------------------
	task automatic tok(input logic o, input logic e);
		@(posedge mclk_i);
		tok_valid_i <= 1'b1;
		tok_out_i <= o;
		tok_ep_i <= e;
		@(posedge mclk_i);
		tok_valid_i <= 1'b0;
	endtask : tok
	task automatic get_hs(input logic [1:0] e);
		int k;
		#1;
		for (k = 0; k < 8 && hs_valid_o !== 1'b1; k++) begin
			@(posedge mclk_i);
			#1;
		end
		if (k == 8) begin
			n_mismatch++;
			results();
		end
		chk(hs_code_o, e);
	endtask : get_hs
	task automatic out(input logic e, input int n, input logic [1:0] h);
		int k;
		tok(1'b1, e);
		for (k = 0; k < n; k++) begin
			rx_valid_i <= 1'b1;
			rx_byte_i <= 8'(8'h30 + k);
			@(posedge mclk_i);
		end
		rx_valid_i <= 1'b0;
		rx_end_i <= 1'b1;
		@(posedge mclk_i);
		rx_end_i <= 1'b0;
		get_hs(h);
	endtask : out
	task automatic take(input logic e, input int n, input logic [7:0] b, input logic a);
		int k;
		int j;
		k = 0;
		tok(1'b0, e);
		for (j = 0; j < 20 && tx_done_o !== 1'b1; j++) begin
			@(posedge mclk_i);
			#1;
			if (tx_valid_o === 1'b1) begin
				chk(tx_byte_o, 8'(b + k));
				k++;
			end
		end
		if (j == 20) begin
			n_mismatch++;
			results();
		end
		chk(32'(k), 32'(n));
		@(posedge mclk_i);
		hs_valid_i <= 1'b1;
		hs_ack_i <= a;
		@(posedge mclk_i);
		hs_valid_i <= 1'b0;
	endtask : take
	// ------------------------------
	// Main sequence.
	// ------------------------------
	initial begin
		repeat (6) @(posedge mclk_i);
		resetn_i <= 1'b1;
		rd(sa(0), 32'h1_0fff, 32'h0);
		rd(sa(1), 32'h1_00ff, 32'h40);
		rd(8'hf0, 32'hffff_ffff, 32'h0);
		tok(1'b0, 1'b0);
		get_hs(usb_ep_pkg::HS_NAK);
		for (i = 0; i < 3; i++) begin
			cmd(usb_ep_pkg::OP_FIFO_WR, 1'b0, 8'(8'h11 + i), 1'b0);
		end
		cmd(usb_ep_pkg::OP_SET_TXRDY, 1'b0, 8'h00, 1'b0);
		rd(sa(0), 32'h1_00ff, 32'h1);
		take(1'b0, 3, 8'h11, 1'b0);
		rd(sa(0), 32'h1_00ff, 32'h1);
		take(1'b0, 3, 8'h11, 1'b1);
		rd(sa(0), 32'h1_00ff, 32'h1_0002);
		cmd(usb_ep_pkg::OP_CLR_TX_COMPLETE, 1'b0, 8'h00, 1'b0);
		rd(sa(0), 32'h1_00ff, 32'h1_0002);
		rd(usb_ep_pkg::REG_RDATA, 32'h100, 32'h100);
		cmd(usb_ep_pkg::OP_SET_TXRDY, 1'b0, 8'h00, 1'b0);
		cmd(usb_ep_pkg::OP_CLR_TX_COMPLETE, 1'b0, 8'h00, 1'b0);
		rd(sa(0), 32'h1_00ff, 32'h1);
		take(1'b0, 0, 8'h00, 1'b1);
		cmd(usb_ep_pkg::OP_CLR_TX_COMPLETE, 1'b0, 8'h00, 1'b1);
		rd(sa(0), 32'h1_00ff, 32'h0);
		for (i = 0; i < 4; i++) begin
			cmd(usb_ep_pkg::OP_FIFO_WR, 1'b1, 8'(8'h20 + i), 1'b0);
			if (i == 1 || i == 3) begin
				cmd(usb_ep_pkg::OP_SET_TXRDY, 1'b1, 8'h00, 1'b0);
			end
		end
		take(1'b1, 2, 8'h20, 1'b1);
		rd(sa(1), 32'h1_00ff, 32'h1_0042);
		cmd(usb_ep_pkg::OP_SET_TXRDY, 1'b1, 8'h00, 1'b0);
		cmd(usb_ep_pkg::OP_CLR_TX_COMPLETE, 1'b1, 8'h00, 1'b0);
		take(1'b1, 2, 8'h22, 1'b1);
		cmd(usb_ep_pkg::OP_CLR_TX_COMPLETE, 1'b1, 8'h00, 1'b1);
		out(1'b0, 3, usb_ep_pkg::HS_ACK);
		rd(sa(0), 32'h1_0fff, 32'h1_0304);
		out(1'b0, 1, usb_ep_pkg::HS_NAK);
		for (i = 0; i < 3; i++) begin
			cmd(usb_ep_pkg::OP_FIFO_RD, 1'b0, 8'h00, 1'b0);
			rd(usb_ep_pkg::REG_RDATA, 32'hff, 8'(8'h30 + i));
		end
		cmd(usb_ep_pkg::OP_CLR_RXB0, 1'b0, 8'h00, 1'b0);
		rd(sa(0), 32'h1_00ff, 32'h0);
		out(1'b1, 2, usb_ep_pkg::HS_ACK);
		out(1'b1, 1, usb_ep_pkg::HS_ACK);
		out(1'b1, 1, usb_ep_pkg::HS_NAK);
		rd(sa(1), 32'h1_00ff, 32'h1_004c);
		cmd(usb_ep_pkg::OP_CLR_RXB1, 1'b1, 8'h00, 1'b0);
		cmd(usb_ep_pkg::OP_CLR_RXB0, 1'b1, 8'h00, 1'b0);
		rd(sa(1), 32'h1_00ff, 32'h1_0048);
		cmd(usb_ep_pkg::OP_CLR_RXB1, 1'b1, 8'h00, 1'b0);
		out(1'b1, 1, usb_ep_pkg::HS_ACK);
		rd(sa(1), 32'h1_00ff, 32'h1_0044);
		cmd(usb_ep_pkg::OP_SET_STALL, 1'b0, 8'h00, 1'b0);
		tok(1'b0, 1'b0);
		get_hs(usb_ep_pkg::HS_STALL);
		out(1'b0, 1, usb_ep_pkg::HS_STALL);
		rd(sa(0), 32'h1_00ff, 32'h1_0030);
		rd(sa(1), 32'h1_00ff, 32'h1_0044);
		cmd(usb_ep_pkg::OP_CLR_STALL, 1'b0, 8'h00, 1'b0);
		cmd(usb_ep_pkg::OP_CLR_STALL_HANDSHAKE_SENT, 1'b0, 8'h00, 1'b0);
		rd(sa(0), 32'h1_00ff, 32'h0);
		tok(1'b0, 1'b0);
		get_hs(usb_ep_pkg::HS_NAK);
		results();
	end
endmodule : tb_top
